// ===== inc/irb_pkg.sv
// constants, register map and state type of the interrupt register bank
package irb_pkg;

   // sizes of the bank
   localparam int IRB_WORDS   = 36;
   localparam int IRB_FLAGS   = 9;
   localparam int IRB_SLOTS   = 64;
   localparam int IRB_SOURCES = 144;
   localparam int IRB_EVENTS  = 3;

   // word positions inside the bank
   localparam int IRB_FIRST_FLAG   = 0;
   localparam int IRB_FIRST_ENABLE = 9;
   localparam int IRB_FIRST_PRIO   = 18;
   localparam int IRB_SOFT_TRAP    = 34;
   localparam int IRB_HARD_TRAP    = 35;

   // register indices; the bus byte address is four times the index
   localparam logic [13:0] IRB_INDEX [IRB_WORDS] = '{
      14'h0800, 14'h0802, 14'h0804, 14'h0806, 14'h0808, 14'h080a, 14'h080c, 14'h0810, 14'h0812,
      14'h0820, 14'h0822, 14'h0824, 14'h0826, 14'h0828, 14'h082a, 14'h082c, 14'h0830, 14'h0832,
      14'h0840, 14'h0842, 14'h0844, 14'h0846, 14'h0848, 14'h084a, 14'h084c, 14'h084e,
      14'h0850, 14'h0852, 14'h0858, 14'h085c, 14'h0860, 14'h0866, 14'h086e, 14'h0870,
      14'h0880, 14'h0882};
   localparam logic [13:0] IRB_IRQ_STATUS_INDEX = 14'h0884;
   localparam logic [13:0] IRB_IRQ_MASK_INDEX   = 14'h0886;

   // implemented bits of each word; all others read as zero
   localparam logic [15:0] IRB_MASK [IRB_WORDS] = '{
      16'h7fff, 16'hff1f, 16'h0073, 16'h0606, 16'h200e, 16'hc000, 16'h0001, 16'hc000, 16'h007e,
      16'h7fff, 16'hff1f, 16'h0073, 16'h0606, 16'h200e, 16'hc000, 16'h0001, 16'hc000, 16'h007e,
      16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7777, 16'h0007, 16'h7777, 16'h7777,
      16'h0077, 16'h0777, 16'h0770, 16'h0770, 16'h7770, 16'h0070, 16'h7700, 16'h7007,
      16'h0030, 16'h0001};

   // reset value of each word
   localparam logic [15:0] IRB_RESET [IRB_WORDS] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h4444, 16'h0004, 16'h4444, 16'h4444,
      16'h0044, 16'h0444, 16'h0440, 16'h0440, 16'h4440, 16'h0040, 16'h4400, 16'h4004,
      16'h0000, 16'h0000};

   // source number (flag word * 16 + bit) behind each priority nibble, 8'hff when none
   localparam logic [7:0] IRB_NO_SOURCE = 8'hff;
   localparam logic [7:0] IRB_SLOT_SRC [IRB_SLOTS] = '{
      8'h00, 8'h01, 8'h02, 8'h03,  8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0a, 8'h0b,  8'h0c, 8'h0d, 8'h0e, 8'hff,
      8'h10, 8'h11, 8'h12, 8'h13,  8'h14, 8'hff, 8'hff, 8'hff,
      8'h18, 8'h19, 8'h1a, 8'h1b,  8'h1c, 8'h1d, 8'h1e, 8'h1f,
      8'h20, 8'h21, 8'hff, 8'hff,  8'h24, 8'h25, 8'h26, 8'hff,
      8'hff, 8'h31, 8'h32, 8'hff,  8'hff, 8'h39, 8'h3a, 8'hff,
      8'hff, 8'h41, 8'h42, 8'h43,  8'hff, 8'h4d, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h5e, 8'h5f,  8'h60, 8'hff, 8'hff, 8'hff};

   // trap status bit positions
   localparam int IRB_DMA_ADDR_ERR_BIT   = 5;
   localparam int IRB_LOOP_STACK_OVF_BIT = 4;
   localparam int IRB_SW_HARD_TRAP_BIT   = 0;

   // interrupt status bit positions and reset values
   localparam int IRB_EV_DMA_ADDR_ERR     = 0;
   localparam int IRB_EV_LOOP_STACK_OVF   = 1;
   localparam int IRB_EV_SW_HARD_TRAP     = 2;
   localparam logic [2:0] IRB_IRQ_RESET   = 3'h0;

   // state of the bank top level
   typedef struct packed {
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
      logic [2:0]    irq_status;
      logic [2:0]    irq_mask;
      logic          irq;
      logic [63:0]   slot_req;
      logic [191:0]  slot_prio;
   } irb_state_s;

   // state of one register word
   typedef struct packed {
      logic [15:0] value;
   } irb_word_s;

endpackage : irb_pkg

// ===== tb/irb_bank_tb.sv
// self-checking bench for the interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module irb_bank_tb;
   import irb_pkg::*;
   logic         i_clock = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, fire = 1'b0;
   logic [15:0]  i_paddr = 16'h0, d;
   logic [31:0]  i_pwdata = 32'h0, o_prdata;
   logic         o_pready, o_pslverr, o_irq;
   logic [146:0] pattern = '0, pulse_v;
   logic [63:0]  o_slot_req;
   logic [191:0] o_slot_prio;
   logic [32:0]  exp_q[$];
   logic [15:0]  want[IRB_WORDS];
   int           fails = 0, total_checks = 0;
   always #25 i_clock = ~i_clock;
   irb_bank uut (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .i_src_event(pulse_v[143:0]), .i_dma_addr_err_trap(pulse_v[144]),
      .i_loop_stack_ovf_trap(pulse_v[145]), .i_sw_hard_trap(pulse_v[146]), .o_slot_req, .o_slot_prio, .o_irq);
   irb_src_model model (.i_clock, .i_rst_n, .i_fire(fire), .i_pattern(pattern), .o_pulse(pulse_v));
   task automatic check(input logic [32:0] seen, input logic [32:0] exp_v);
      total_checks++;
      if (seen !== exp_v) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // one apb transfer; the expected answer is noted first
   task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] v, input logic [32:0] e);
      @(posedge i_clock);
      exp_q.push_back(e);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {16'h0, v};
      @(posedge i_clock);
      i_penable <= 1'b1;
      do @(posedge i_clock); while (o_pready !== 1'b1);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic read_all();
      for (int w = 0; w < IRB_WORDS; w++)
         apb(1'b0, {IRB_INDEX[w], 2'b00}, 16'h0, {17'h0, want[w]});
   endtask : read_all
   task automatic do_reset();
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      want = IRB_RESET;
   endtask : do_reset
   task automatic pulse(input logic [146:0] p);
      pattern <= p;
      fire <= 1'b1;
      @(posedge i_clock);
      fire <= 1'b0;
      repeat (3) @(posedge i_clock);
   endtask : pulse
   // compare each bus answer with the oldest note
   always @(posedge i_clock) begin
      if (i_psel && i_penable && o_pready === 1'b1) begin
         if (i_pwrite) check({o_pslverr, 32'h0}, {exp_q[0][32], 32'h0});
         else check({o_pslverr, o_prdata}, exp_q[0]);
         void'(exp_q.pop_front());
      end
   end
   // watchdog: the tests need well under 5000 cycles
   initial begin
      #(20000 * 50);
      fails++;
      test_done();
   end
   initial begin
      void'($urandom(8428));
      do_reset();
      read_all();
      $display("reset values done");
      // all ones, then random words, read back through the masks
      for (int k = 0; k < 2; k++) begin
         for (int w = 0; w < IRB_WORDS; w++) begin
            d = k ? 16'($urandom) : 16'hffff;
            apb(1'b1, {IRB_INDEX[w], 2'b00}, d, 33'h0);
            want[w] = d & IRB_MASK[w];
         end
         read_all();
      end
      apb(1'b1, 16'h0004, 16'hffff, {1'b1, 32'h0});
      apb(1'b0, 16'h0000, 16'h0, {1'b1, 32'h0});
      $display("write and read back done");
      // second reset, then random source events with all traps
      do_reset();
      for (int i = 0; i < 144; i++)
         pattern[i] = 1'($urandom);
      pulse({3'h7, pattern[143:1], 1'b1});
      for (int f = 0; f < IRB_FLAGS; f++)
         want[f] = pattern[f*16 +: 16] & IRB_MASK[f];
      want[0][0] = 1'b1;
      want[IRB_SOFT_TRAP] = 16'h0030;
      want[IRB_HARD_TRAP] = 16'h0001;
      read_all();
      $display("events done");
      // request needs flag and enable, priority travels with it
      check({31'h0, o_slot_req[1:0]}, 33'h0);
      apb(1'b1, {IRB_INDEX[IRB_FIRST_ENABLE], 2'b00}, 16'h0001, 33'h0);
      repeat (3) @(posedge i_clock);
      check({25'h0, o_slot_req[1:0], o_slot_prio[5:0]}, {25'h0, 2'b01, 6'h04});
      apb(1'b1, {IRB_INDEX[IRB_FIRST_FLAG], 2'b00}, 16'h0, 33'h0);
      repeat (3) @(posedge i_clock);
      check({29'h0, o_slot_req[0], o_slot_prio[2:0]}, 33'h0);
      $display("requests done");
      // masked interrupt, unmask, read-clear
      check({32'h0, o_irq}, 33'h0);
      apb(1'b1, {IRB_IRQ_MASK_INDEX, 2'b00}, 16'h0004, 33'h0);
      repeat (3) @(posedge i_clock);
      check({32'h0, o_irq}, 33'h1);
      apb(1'b0, {IRB_IRQ_STATUS_INDEX, 2'b00}, 16'h0, 33'h7);
      repeat (3) @(posedge i_clock);
      check({32'h0, o_irq}, 33'h0);
      $display("interrupt done");
      test_done();
   end
endmodule : irb_bank_tb
bind irb_bank irb_monitor mon (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .o_prdata, .o_pready,
   .o_pslverr, .i_dma_addr_err_trap, .i_loop_stack_ovf_trap, .i_sw_hard_trap, .o_slot_req, .o_slot_prio, .o_irq);
`default_nettype wire

// ===== tb/irb_monitor.sv
// assertion checker watching the ports of the interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module irb_monitor (
   // clock, reset and bus
   input wire logic         i_clock,
   input wire logic         i_rst_n,
   input wire logic         i_psel,
   input wire logic         i_penable,
   input wire logic         i_pwrite,
   input wire logic [31:0]  o_prdata,
   input wire logic         o_pready,
   input wire logic         o_pslverr,
   // events and requests
   input wire logic         i_dma_addr_err_trap,
   input wire logic         i_loop_stack_ovf_trap,
   input wire logic         i_sw_hard_trap,
   input wire logic [63:0]  o_slot_req,
   input wire logic [191:0] o_slot_prio,
   input wire logic         o_irq
);
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // helper terms for bus accesses and trap events
   wire acc = i_psel && i_penable;
   wire wr  = acc && i_pwrite;
   wire ev  = i_dma_addr_err_trap || i_loop_stack_ovf_trap || i_sw_hard_trap;
   sequence s_setup; i_psel && !i_penable; endsequence
   sequence s_answer; o_pready ##1 !o_pready; endsequence
   property p_answer; s_setup |=> s_answer; endproperty
   a_answer: assert property (p_answer) else $error("answer missing or not one cycle");
   property p_upper; o_pready |-> o_prdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read half not zero");
   property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("error answer malformed");
   property p_prio0; !o_slot_req[0] |-> o_slot_prio[2:0] == 3'h0; endproperty
   a_prio0: assert property (p_prio0) else $error("priority without request");
   property p_fall; $fell(o_slot_req[0]) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3); endproperty
   a_fall: assert property (p_fall) else $error("request dropped without write");
   property p_irq_up; $rose(o_irq) |-> $past(ev, 1) || $past(ev, 2) || $past(wr, 1) || $past(wr, 2); endproperty
   a_irq_up: assert property (p_irq_up) else $error("interrupt rose without cause");
   property p_irq_dn; $fell(o_irq) |-> $past(acc, 1) || $past(acc, 2); endproperty
   a_irq_dn: assert property (p_irq_dn) else $error("interrupt fell without access");
endmodule : irb_monitor
`default_nettype wire

// ===== tb/irb_src_model.sv
// peripheral event source model: one request becomes one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module irb_src_model (
   // clock, reset and request
   input  wire logic         i_clock,
   input  wire logic         i_rst_n,
   input  wire logic         i_fire,
   input  wire logic [146:0] i_pattern,
   // pulses towards the bank
   output logic      [146:0] o_pulse
);
   // pulse for one cycle, quiet otherwise
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) o_pulse <= '0;
      else o_pulse <= i_fire ? i_pattern : '0;
   end
endmodule : irb_src_model
`default_nettype wire

// ===== verilog/irb_bank.sv
// interrupt register bank: flags, enables, priorities, trap status over apb
//
// Contract
// - every source in flag words 0 to 6 has a 3-bit priority nibble, top bit zero, reset to four; flag words 7 and 8 have none
// - unimplemented bits of all bank registers always read back as zero
// - flags from 0x0800, enables from 0x0820, same bit position, reset clears
// - soft trap bit 5 records a dma address error trap, read-write, reset zero
// - soft trap bit 4 records a loop stack overflow trap, read-write, reset zero
// - hard trap bit 0 records a software hard trap; bits 15..1 unimplemented
`timescale 1ns/1ps
`default_nettype none
module irb_bank (
   // clock and reset
   input  wire logic                            i_clock,
   input  wire logic                            i_rst_n,
   // apb slave
   input  wire logic                            i_psel,
   input  wire logic                            i_penable,
   input  wire logic                            i_pwrite,
   input  wire logic [15:0]                     i_paddr,
   input  wire logic [31:0]                     i_pwdata,
   output logic      [31:0]                     o_prdata,
   output logic                                 o_pready,
   output logic                                 o_pslverr,
   // peripheral source events, one-cycle pulses, same clock
   input  wire logic [irb_pkg::IRB_SOURCES-1:0] i_src_event,
   // trap events, one-cycle pulses, same clock
   input  wire logic                            i_dma_addr_err_trap,
   input  wire logic                            i_loop_stack_ovf_trap,
   input  wire logic                            i_sw_hard_trap,
   // requests to the core, one per priority slot
   output logic      [irb_pkg::IRB_SLOTS-1:0]   o_slot_req,
   output logic      [irb_pkg::IRB_SLOTS*3-1:0] o_slot_prio,
   // interrupt line
   output logic                                 o_irq
);
   import irb_pkg::*;

   irb_state_s         st;
   irb_state_s         next_st;
   logic [15:0]        word_value [IRB_WORDS];
   logic [15:0]        word_set   [IRB_WORDS];
   logic [IRB_WORDS-1:0] word_hit;
   logic [IRB_WORDS-1:0] word_wr;
   logic [IRB_SLOTS-1:0] slot_req;
   logic [2:0]         slot_prio  [IRB_SLOTS];
   logic [IRB_SOURCES-1:0] flag_bits;
   logic [IRB_SOURCES-1:0] enable_bits;
   logic [13:0]        index;
   logic               setup;
   logic               access;
   logic               irq_status_hit;
   logic               irq_mask_hit;
   logic [2:0]         events;

   // bus phases; the write and read-clear take effect at the access edge
   assign index          = i_paddr[15:2];
   assign setup          = i_psel & ~i_penable;
   assign access         = i_psel & i_penable & st.pready;
   assign irq_status_hit = (index == IRB_IRQ_STATUS_INDEX);
   assign irq_mask_hit   = (index == IRB_IRQ_MASK_INDEX);

   // trap pulses feeding the interrupt status
   assign events[IRB_EV_DMA_ADDR_ERR]   = i_dma_addr_err_trap;
   assign events[IRB_EV_LOOP_STACK_OVF] = i_loop_stack_ovf_trap;
   assign events[IRB_EV_SW_HARD_TRAP]   = i_sw_hard_trap;

   // register words: decode, hardware set and storage
   generate
      for (genvar w = 0; w < IRB_WORDS; w++) begin : g_word
         assign word_hit[w] = (index == IRB_INDEX[w]);
         assign word_wr[w]  = access & i_pwrite & word_hit[w];
         if (w < IRB_FIRST_ENABLE) begin : g_flag
            assign word_set[w] = i_src_event[w*16 +: 16];
         end else if (w == IRB_SOFT_TRAP) begin : g_soft
            // one driver per word: trap pulses placed at their status bits
            assign word_set[w] = (16'(i_dma_addr_err_trap) << IRB_DMA_ADDR_ERR_BIT)
                               | (16'(i_loop_stack_ovf_trap) << IRB_LOOP_STACK_OVF_BIT);
         end else if (w == IRB_HARD_TRAP) begin : g_hard
            assign word_set[w] = 16'(i_sw_hard_trap) << IRB_SW_HARD_TRAP_BIT;
         end else begin : g_plain
            assign word_set[w] = 16'h0000;
         end
         irb_word #(
            .MASK  (IRB_MASK[w]),
            .RESET (IRB_RESET[w])
         ) u_word (
            .i_clock (i_clock),
            .i_rst_n (i_rst_n),
            .i_wr    (word_wr[w]),
            .i_wdata (i_pwdata[15:0]),
            .i_set   (word_set[w]),
            .o_value (word_value[w])
         );
      end
   endgenerate

   // flag and enable words laid out as flat source vectors
   generate
      for (genvar f = 0; f < IRB_FLAGS; f++) begin : g_src
         assign flag_bits[f*16 +: 16]   = word_value[IRB_FIRST_FLAG + f];
         assign enable_bits[f*16 +: 16] = word_value[IRB_FIRST_ENABLE + f];
      end
   endgenerate

   // per priority nibble: request and its priority field
   generate
      for (genvar s = 0; s < IRB_SLOTS; s++) begin : g_slot
         if (IRB_SLOT_SRC[s] == IRB_NO_SOURCE) begin : g_none
            assign slot_req[s]  = 1'b0;
            assign slot_prio[s] = 3'h0;
         end else begin : g_used
            assign slot_req[s]  = flag_bits[IRB_SLOT_SRC[s]] & enable_bits[IRB_SLOT_SRC[s]];
            assign slot_prio[s] = word_value[IRB_FIRST_PRIO + s/4][(s%4)*4 +: 3];
         end
      end
   endgenerate

   // next state: bus answer, interrupt status and mask, request outputs
   always_comb begin
      next_st = st;
      // answer one cycle after setup, so every access has no wait state
      next_st.pready  = setup;
      next_st.pslverr = 1'b0;
      if (setup) begin
         next_st.prdata  = 32'h0000_0000;
         next_st.pslverr = ~(|word_hit | irq_status_hit | irq_mask_hit);
         for (int w = 0; w < IRB_WORDS; w++) begin
            if (word_hit[w]) begin
               next_st.prdata[15:0] = word_value[w];
            end
         end
         if (irq_status_hit) begin
            next_st.prdata[2:0] = st.irq_status;
         end
         if (irq_mask_hit) begin
            next_st.prdata[2:0] = st.irq_mask;
         end
      end else begin
         // read data stands only in the answer cycle
         next_st.prdata = 32'h0000_0000;
      end
      // read clears the status; a new event in the same cycle survives
      if (access && !i_pwrite && irq_status_hit) begin
         next_st.irq_status = 3'h0;
      end
      next_st.irq_status = next_st.irq_status | events;
      if (access && i_pwrite && irq_mask_hit) begin
         next_st.irq_mask = i_pwdata[2:0];
      end
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);
      // registered requests and priorities
      for (int s = 0; s < IRB_SLOTS; s++) begin
         next_st.slot_req[s]            = slot_req[s];
         next_st.slot_prio[s*3 +: 3]    = slot_req[s] ? slot_prio[s] : 3'h0;
      end
   end

   // state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st.pready     <= 1'b0;
         st.pslverr    <= 1'b0;
         st.prdata     <= 32'h0000_0000;
         st.irq_status <= IRB_IRQ_RESET;
         st.irq_mask   <= IRB_IRQ_RESET;
         st.irq        <= 1'b0;
         st.slot_req   <= '0;
         st.slot_prio  <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign o_prdata    = st.prdata;
   assign o_pready    = st.pready;
   assign o_pslverr   = st.pslverr;
   assign o_slot_req  = st.slot_req;
   assign o_slot_prio = st.slot_prio;
   assign o_irq       = st.irq;
endmodule : irb_bank
`default_nettype wire

// ===== verilog/irb_word.sv
// one 16-bit register word with implemented-bit mask and hardware set
`timescale 1ns/1ps
`default_nettype none
module irb_word #(
   parameter logic [15:0] MASK  = 16'hffff,
   parameter logic [15:0] RESET = 16'h0000
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // software write
   input  wire logic        i_wr,
   input  wire logic [15:0] i_wdata,
   // hardware set, one bit per position
   input  wire logic [15:0] i_set,
   // stored value
   output logic      [15:0] o_value
);
   import irb_pkg::*;

   irb_word_s st;
   irb_word_s next_st;

   // set wins over a write of zero in the same cycle; holes stay zero
   always_comb begin
      next_st = st;
      if (i_wr) begin
         next_st.value = i_wdata;
      end
      next_st.value = (next_st.value | i_set) & MASK;
   end

   // state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st.value <= RESET & MASK;
      end else begin
         st <= next_st;
      end
   end

   assign o_value = st.value;
endmodule : irb_word
`default_nettype wire
